// *** rtl/ata_task_file_registers.sv ***
/*
 * Command-block task file of the drive in legacy mode. The host register
 * frame arrives as a struct with a one-cycle valid; the device-to-host
 * frame leaves as a struct with a one-cycle valid at command end. Words of
 * the data port pass through a one-sector buffer shared with the core.
 * Assumes every input comes from logic on clk, framing done elsewhere.
 */
`include "ata_tf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module ata_task_file_registers (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire ata_tf_pkg::host_tf_t          hostTf,
    input  wire logic                          hostTfValid,
    input  wire logic [`BUF_DATA_BITS-1:0]     hostWrData,
    input  wire logic                          hostWrValid,
    input  wire logic                          hostRdReq,
    output var  logic [`BUF_DATA_BITS-1:0]     hostRdData_q,
    output var  logic                          hostRdValid_q,
    output var  ata_tf_pkg::dev_tf_t           devTf_q,
    output var  logic                          devTfValid_q,
    output var  logic                          busy_q,
    output var  logic                          cmdStart_q,
    output var  ata_tf_pkg::core_cmd_t         cmd_q,
    input  wire logic                          coreSectorDone,
    input  wire logic                          coreCmdEnd,
    input  wire ata_tf_pkg::err_evt_t          coreErr,
    input  wire logic                          coreBufWe,
    input  wire logic [`BUF_ADDR_BITS-1:0]     coreBufAddr,
    input  wire logic [`BUF_DATA_BITS-1:0]     coreBufWrData,
    output var  logic [`BUF_DATA_BITS-1:0]     coreBufRdData_q
);

    ata_tf_pkg::tf_state_t         state_q;
    ata_tf_pkg::tf_state_t         state_d;
    ata_tf_pkg::host_tf_t          tf_q;
    ata_tf_pkg::host_tf_t          tf_d;
    logic [8:0]                    remain_q;
    logic [8:0]                    remain_d;
    logic                          statErr_q;
    logic                          statErr_d;
    logic                          cmdStart_d;
    ata_tf_pkg::core_cmd_t         cmd_d;
    ata_tf_pkg::dev_tf_t           devTf_d;
    logic                          devTfValid_d;
    logic [`BUF_ADDR_BITS-1:0]     hostPtr_q;
    logic [`BUF_ADDR_BITS-1:0]     hostPtr_d;
    logic                          hostRdValid_d;
    logic                          accept;
    logic                          anyErr;
    logic [7:0]                    errSet;
    logic [7:0]                    errFlags;
    logic [7:0]                    errNow;
    logic [7:0]                    devHeadNew;
    logic                          busy_d;

    // A frame while a command runs is dropped; one device, no selection
    assign accept = hostTfValid && (state_q == ata_tf_pkg::TF_IDLE);

    // Drive number bit is ignored; bits 7 and 5 are kept as written
    assign devHeadNew = hostTf.devHead;

    always_comb begin
        errSet = 8'h00;
        errSet[`ERR_BAD_BLOCK_BIT]     = coreErr.badBlock;
        errSet[`ERR_UNCORRECTABLE_BIT] = coreErr.uncorrectable;
        errSet[`ERR_ID_NOT_FOUND_BIT]  = coreErr.idNotFound;
        errSet[`ERR_ABORTED_BIT]       = coreErr.aborted;
        errSet[`ERR_GENERAL_BIT]       = coreErr.general;
    end

    error_cause_flags u_flags (
        .clk     (clk),
        .resetn  (resetn),
        .clear   (accept),
        .setVec  (errSet & {8{state_q == ata_tf_pkg::TF_BUSY}}),
        .flags_q (errFlags)
    );

    // Flags as they stand once this cycle's events are taken in
    assign errNow = errFlags | (errSet & `ERR_LIVE_MASK);
    assign anyErr = |errNow;

    always_comb begin
        state_d      = state_q;
        tf_d         = tf_q;
        remain_d     = remain_q;
        statErr_d    = statErr_q;
        cmdStart_d   = 1'b0;
        cmd_d        = cmd_q;
        devTf_d      = devTf_q;
        devTfValid_d = 1'b0;
        unique case (state_q)
            ata_tf_pkg::TF_IDLE: begin
                if (accept) begin
                    tf_d         = hostTf;
                    tf_d.devHead = devHeadNew;
                    statErr_d    = 1'b0;
                    if (hostTf.count == `TF_RESET_BYTE) begin
                        remain_d = `COUNT_ZERO_SECTORS;
                    end else begin
                        remain_d = {1'b0, hostTf.count};
                    end
                    cmd_d.code     = hostTf.command;
                    cmd_d.feature  = hostTf.feature;
                    cmd_d.lbaMode  = hostTf.devHead[`DEVHEAD_LBA_BIT];
                    cmd_d.lba      = {hostTf.devHead[3:0],
                                      hostTf.cylHigh,
                                      hostTf.cylLow,
                                      hostTf.sectorNum};
                    cmd_d.cylinder = {hostTf.cylHigh,
                                      hostTf.cylLow};
                    cmd_d.head     = hostTf.devHead[3:0];
                    cmd_d.sector   = hostTf.sectorNum;
                    cmd_d.sectors  = remain_d;
                    cmdStart_d     = 1'b1;
                    state_d        = ata_tf_pkg::TF_BUSY;
                end
            end
            ata_tf_pkg::TF_BUSY: begin
                if (coreSectorDone && (remain_q != 9'h000)) begin
                    remain_d = remain_q - 9'h001;
                end
                if (coreCmdEnd) begin
                    if (!anyErr) begin
                        remain_d = 9'h000;
                    end
                    statErr_d            = anyErr;
                    devTf_d.status       = 8'h00;
                    devTf_d.status[`STATUS_ERR_BIT] = anyErr;
                    devTf_d.errorCause   = errNow;
                    devTf_d.count        = remain_d[7:0];
                    devTf_d.sectorNum    = tf_q.sectorNum;
                    devTf_d.cylLow       = tf_q.cylLow;
                    devTf_d.cylHigh      = tf_q.cylHigh;
                    devTf_d.devHead      = tf_q.devHead;
                    devTfValid_d         = 1'b1;
                    state_d              = ata_tf_pkg::TF_IDLE;
                end
            end
        endcase
        tf_d.count = remain_d[7:0];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q      <= ata_tf_pkg::TF_IDLE;
            tf_q         <= '{command:   `TF_RESET_BYTE,
                              feature:   `TF_RESET_BYTE,
                              count:     `TF_RESET_BYTE,
                              sectorNum: `TF_RESET_BYTE,
                              cylLow:    `TF_RESET_BYTE,
                              cylHigh:   `TF_RESET_BYTE,
                              devHead:   `DEVHEAD_RESET};
            remain_q     <= 9'h000;
            statErr_q    <= 1'b0;
            cmdStart_q   <= 1'b0;
            cmd_q        <= '0;
            devTf_q      <= '{status:     `TF_RESET_BYTE,
                              errorCause: `TF_RESET_BYTE,
                              count:      `TF_RESET_BYTE,
                              sectorNum:  `TF_RESET_BYTE,
                              cylLow:     `TF_RESET_BYTE,
                              cylHigh:    `TF_RESET_BYTE,
                              devHead:    `DEVHEAD_RESET};
            devTfValid_q <= 1'b0;
            busy_q       <= 1'b0;
        end else begin
            state_q      <= state_d;
            tf_q         <= tf_d;
            remain_q     <= remain_d;
            statErr_q    <= statErr_d;
            cmdStart_q   <= cmdStart_d;
            cmd_q        <= cmd_d;
            devTf_q      <= devTf_d;
            devTfValid_q <= devTfValid_d;
            busy_q       <= busy_d;
        end
    end

    // Busy flop mirrors the state register so the output comes from a flop
    always_comb begin
        busy_d = (state_d == ata_tf_pkg::TF_BUSY);
    end

    // Host word pointer restarts with each accepted command
    always_comb begin
        hostPtr_d     = hostPtr_q;
        hostRdValid_d = 1'b0;
        if (accept) begin
            hostPtr_d = '0;
        end else if (hostWrValid) begin
            hostPtr_d = hostPtr_q + 8'h01;
        end else if (hostRdReq) begin
            hostPtr_d     = hostPtr_q + 8'h01;
            hostRdValid_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hostPtr_q     <= '0;
            hostRdValid_q <= 1'b0;
        end else begin
            hostPtr_q     <= hostPtr_d;
            hostRdValid_q <= hostRdValid_d;
        end
    end

    // No alternate status copy: the returned frame is the only status view
    sector_buffer u_buf (
        .clk       (clk),
        .aWe       (hostWrValid && !accept),
        .aAddr     (hostPtr_q),
        .aWrData   (hostWrData),
        .aRdData_q (hostRdData_q),
        .bWe       (coreBufWe),
        .bAddr     (coreBufAddr),
        .bWrData   (coreBufWrData),
        .bRdData_q (coreBufRdData_q)
    );

endmodule

`default_nettype wire

// *** rtl/ata_tf_cfg.svh ***
/*
 * Constants of the command-block task file: field positions inside the
 * error cause and device/head registers, reset values and buffer size.
 * Assumes it is included by bare name before any use of its macros.
 */
// Summary of operation
// - A 16-bit port moves data words between sector buffer and host.
// - Error cause holds valid information whenever status error bit is set.
// - Bad block flag, error cause bit 7, set on a defective block.
// - Uncorrectable flag, error cause bit 6, set on uncorrectable data error.
// - Error cause bits 5, 3 and 1 always read as zero.
// - Id-not-found flag, bit 4, set when sector identifier is invalid.
// - Command-aborted flag, bit 2, set when a command is aborted.
// - General error flag, bit 0, set on any general error.
// - A sector count of zero requests 256 sectors.
// - Sector count reads zero after a successful data transfer command.
// - After failure, sector count holds the sectors still needed.
// - Sector number is start sector or logical address bits 7-0.
// - Cylinder low is cylinder low byte or logical address bits 15-8.
// - Cylinder high is cylinder high byte or logical address bits 23-16.
// - Device/head bit 6 selects geometric (0) or logical (1) addressing.
// - Device/head low nibble is head number or logical bits 27-24.
// - Only device on the channel; no primary/secondary selection.
// - Task file values travel in fields of frame information structures.
// - No separate alternate status register exists.
// - Status error summary bit 0 set when previous command ended in error.
`ifndef ATA_TF_CFG_SVH
`define ATA_TF_CFG_SVH

`define ERR_BAD_BLOCK_BIT       7
`define ERR_UNCORRECTABLE_BIT   6
`define ERR_ID_NOT_FOUND_BIT    4
`define ERR_ABORTED_BIT         2
`define ERR_GENERAL_BIT         0
`define ERR_LIVE_MASK           8'hD5

`define DEVHEAD_LBA_BIT         6
`define DEVHEAD_DRIVE_BIT       4
`define STATUS_ERR_BIT          0

`define TF_RESET_BYTE           8'h00
`define DEVHEAD_RESET           8'hA0
`define COUNT_ZERO_SECTORS      9'h100

`define BUF_ADDR_BITS           8
`define BUF_DATA_BITS           16

`endif

// *** rtl/ata_tf_pkg.sv ***
/*
 * Types shared by the task file block: the host-written task file, the
 * command handed to the drive core, its error events and the returned
 * task file. Assumes ata_tf_cfg.svh is on the include path.
 */
`include "ata_tf_cfg.svh"

package ata_tf_pkg;

    typedef struct packed {
        logic [7:0] command;
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] sectorNum;
        logic [7:0] cylLow;
        logic [7:0] cylHigh;
        logic [7:0] devHead;
    } host_tf_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [7:0]  feature;
        logic        lbaMode;
        logic [27:0] lba;
        logic [15:0] cylinder;
        logic [3:0]  head;
        logic [7:0]  sector;
        logic [8:0]  sectors;
    } core_cmd_t;

    typedef struct packed {
        logic badBlock;
        logic uncorrectable;
        logic idNotFound;
        logic aborted;
        logic general;
    } err_evt_t;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] errorCause;
        logic [7:0] count;
        logic [7:0] sectorNum;
        logic [7:0] cylLow;
        logic [7:0] cylHigh;
        logic [7:0] devHead;
    } dev_tf_t;

    typedef enum logic {
        TF_IDLE,
        TF_BUSY
    } tf_state_t;

endpackage

// *** rtl/sector_buffer.sv ***
/*
 * Dual-port sector buffer, one 512-byte sector of 16-bit words.
 * Port A faces the host data port, port B the drive core. Read data of
 * both ports come out of registers one cycle after the address.
 */
`include "ata_tf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module sector_buffer (
    input  wire logic                        clk,
    input  wire logic                        aWe,
    input  wire logic [`BUF_ADDR_BITS-1:0]   aAddr,
    input  wire logic [`BUF_DATA_BITS-1:0]   aWrData,
    output var  logic [`BUF_DATA_BITS-1:0]   aRdData_q,
    input  wire logic                        bWe,
    input  wire logic [`BUF_ADDR_BITS-1:0]   bAddr,
    input  wire logic [`BUF_DATA_BITS-1:0]   bWrData,
    output var  logic [`BUF_DATA_BITS-1:0]   bRdData_q
);

    logic [`BUF_DATA_BITS-1:0] mem [0:(1<<`BUF_ADDR_BITS)-1];

    // One process writes the array; on a same-address clash port B wins
    always_ff @(posedge clk) begin
        if (aWe) begin
            mem[aAddr] <= aWrData;
        end
        if (bWe) begin
            mem[bAddr] <= bWrData;
        end
        aRdData_q <= mem[aAddr];
        bRdData_q <= mem[bAddr];
    end

endmodule

`default_nettype wire

// *** rtl/error_cause_flags.sv ***
/*
 * Sticky error cause flags. A set in the same cycle as a clear wins, so
 * no event is lost. Bits outside the live mask are constant zero.
 * Assumes set and clear come from logic on the same clock.
 */
`include "ata_tf_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module error_cause_flags (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       clear,
    input  wire logic [7:0] setVec,
    output var  logic [7:0] flags_q
);

    localparam logic [7:0] LIVE = `ERR_LIVE_MASK;

    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            if (LIVE[i]) begin : g_live
                logic flag_d;
                logic flag_q;
                always_comb begin
                    flag_d = flag_q;
                    if (clear) begin
                        flag_d = 1'b0;
                    end
                    if (setVec[i]) begin
                        flag_d = 1'b1;
                    end
                end
                always_ff @(posedge clk or negedge resetn) begin
                    if (!resetn) begin
                        flag_q <= 1'b0;
                    end else begin
                        flag_q <= flag_d;
                    end
                end
                assign flags_q[i] = flag_q;
            end else begin : g_zero
                assign flags_q[i] = 1'b0;
            end
        end
    endgenerate

endmodule

`default_nettype wire

// *** tb/ata_tf_chk.sv ***
/*
 * Checker for the task file block: accept, completion, error cause
 * and address mapping. Assumes single clock clk and resetn.
 */
`timescale 1ns/1ps
`default_nettype none

module ata_tf_chk (
    input wire logic                  clk,
    input wire logic                  resetn,
    input wire ata_tf_pkg::host_tf_t  hostTf,
    input wire logic                  hostTfValid,
    input wire logic                  hostWrValid,
    input wire logic                  hostRdReq,
    input wire logic                  hostRdValid_q,
    input wire ata_tf_pkg::dev_tf_t   devTf_q,
    input wire logic                  devTfValid_q,
    input wire logic                  busy_q,
    input wire logic                  cmdStart_q,
    input wire ata_tf_pkg::core_cmd_t cmd_q,
    input wire logic                  coreCmdEnd
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence accepted;
        hostTfValid && !busy_q;
    endsequence

    sequence frameOut;
        devTfValid_q && $fell(busy_q);
    endsequence

    a_accept_start: assert property (accepted |=> cmdStart_q && busy_q)
        else $error("accept did not start a command");
    a_start_pulse: assert property (cmdStart_q |=> !cmdStart_q)
        else $error("command start longer than one cycle");
    a_end_frame: assert property (
        coreCmdEnd && busy_q |=> frameOut)
        else $error("command end gave no frame");
    a_zero_bits: assert property (
        (devTf_q.errorCause & 8'h2A) == 8'h00)
        else $error("error cause reserved bits not zero");
    a_err_summary: assert property (
        devTfValid_q |-> devTf_q.status[0] == (|devTf_q.errorCause))
        else $error("status error bit disagrees with cause");
    a_ok_count: assert property (
        devTfValid_q && devTf_q.errorCause == 8'h00
        |-> devTf_q.count == 8'h00)
        else $error("count not zero after success");
    a_addr_map: assert property (
        cmdStart_q |-> cmd_q.lba == {$past(hostTf.devHead[3:0]),
                                     $past(hostTf.cylHigh),
                                     $past(hostTf.cylLow),
                                     $past(hostTf.sectorNum)}
            && cmd_q.lbaMode == $past(hostTf.devHead[6]))
        else $error("address fields mapped wrongly");
    a_zero_count: assert property (
        cmdStart_q |-> cmd_q.sectors ==
            (($past(hostTf.count) == 8'h00) ? 9'h100
                                            : {1'b0, $past(hostTf.count)}))
        else $error("sector count not expanded");
    a_read_answer: assert property (
        hostRdReq && !hostWrValid && !(hostTfValid && !busy_q)
        |=> hostRdValid_q)
        else $error("read request not answered");
endmodule

bind ata_task_file_registers ata_tf_chk chk (.clk, .resetn, .hostTf,
    .hostTfValid, .hostWrValid, .hostRdReq, .hostRdValid_q, .devTf_q,
    .devTfValid_q, .busy_q, .cmdStart_q, .cmd_q, .coreCmdEnd);
`default_nettype wire

// *** tb/host_model.sv ***
/*
 * Host controller model: register frames and data port words.
 * Assumes its tasks are called by the bench on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module host_model (
    input  wire logic                 clk,
    output var  ata_tf_pkg::host_tf_t tf,
    output var  logic                 tfValid,
    output var  logic [15:0]          wrData,
    output var  logic                 wrValid,
    output var  logic                 rdReq
);
    initial begin
        tf = '0;
        tfValid = 1'b0;
        wrData = 16'h0000;
        wrValid = 1'b0;
        rdReq = 1'b0;
    end

    task automatic send(input logic [7:0] cnt, sn, cl, ch,
                        input logic lba, input logic [3:0] hd);
        @(posedge clk);
        tf <= {8'h20, 8'h5A, cnt, sn, cl, ch,
               1'b1, lba, 1'b1, 1'b0, hd};
        tfValid <= 1'b1;
        @(posedge clk);
        tfValid <= 1'b0;
        tf <= ~tf;
    endtask

    task automatic wrWord(input logic [15:0] w);
        @(posedge clk);
        wrData <= w;
        wrValid <= 1'b1;
        @(posedge clk);
        wrValid <= 1'b0;
        wrData <= ~w;
    endtask

    task automatic rdWord();
        @(posedge clk);
        rdReq <= 1'b1;
        @(posedge clk);
        rdReq <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 * Self-checking bench of the task file block with a host model and a
 * hand-driven drive core. Assumes the package and header are compiled.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    ata_tf_pkg::host_tf_t   hostTf;
    logic                   hostTfValid, hostWrValid, hostRdReq;
    logic [15:0]            hostWrData, hostRdData_q, coreBufRdData_q;
    logic                   hostRdValid_q, devTfValid_q, busy_q, cmdStart_q;
    ata_tf_pkg::dev_tf_t    devTf_q;
    ata_tf_pkg::core_cmd_t  cmd_q;
    logic                   coreSectorDone = 1'b0, coreCmdEnd = 1'b0;
    ata_tf_pkg::err_evt_t   coreErr = '0;
    logic                   coreBufWe = 1'b0;
    logic [7:0]             coreBufAddr = 8'h00;
    logic [15:0]            coreBufWrData = 16'h0000;
    int                     fail_count = 0;
    int                     n_checks = 0;

    always #2.5 clk = ~clk;

    host_model host (.clk(clk), .tf(hostTf), .tfValid(hostTfValid),
        .wrData(hostWrData), .wrValid(hostWrValid), .rdReq(hostRdReq));

    ata_task_file_registers dut (.clk(clk), .resetn(resetn),
        .hostTf(hostTf), .hostTfValid(hostTfValid),
        .hostWrData(hostWrData), .hostWrValid(hostWrValid),
        .hostRdReq(hostRdReq), .hostRdData_q(hostRdData_q),
        .hostRdValid_q(hostRdValid_q), .devTf_q(devTf_q),
        .devTfValid_q(devTfValid_q), .busy_q(busy_q),
        .cmdStart_q(cmdStart_q), .cmd_q(cmd_q),
        .coreSectorDone(coreSectorDone), .coreCmdEnd(coreCmdEnd),
        .coreErr(coreErr), .coreBufWe(coreBufWe),
        .coreBufAddr(coreBufAddr), .coreBufWrData(coreBufWrData),
        .coreBufRdData_q(coreBufRdData_q));

    task automatic chk(input logic [31:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish(input int done, input ata_tf_pkg::err_evt_t e);
        repeat (done) begin
            @(posedge clk);
            coreSectorDone <= 1'b1;
            @(posedge clk);
            coreSectorDone <= 1'b0;
        end
        @(posedge clk);
        coreCmdEnd <= 1'b1;
        coreErr <= e;
        @(posedge clk);
        coreCmdEnd <= 1'b0;
        coreErr <= '0;
        #1;
        chk({31'h0, devTfValid_q}, 32'h1);
    endtask

    task automatic t_lba();
        host.send(8'h00, 8'h11, 8'h22, 8'h33, 1'b1, 4'hC);
        #1;
        chk({4'h0, cmd_q.lba}, 32'h0C332211);
        chk({22'h0, cmd_q.lbaMode, cmd_q.sectors}, 32'h300);
        finish(0, '0);
        chk({24'h0, devTf_q.count}, 32'h0);
        chk({16'h0, devTf_q.status, devTf_q.errorCause}, 32'h0);
    endtask

    task automatic t_chs();
        host.send(8'h05, 8'h07, 8'h34, 8'h12, 1'b0, 4'h9);
        #1;
        chk({16'h0, cmd_q.cylinder}, 32'h1234);
        chk({20'h0, cmd_q.sector, cmd_q.head}, 32'h079);
        chk({22'h0, cmd_q.lbaMode, cmd_q.sectors}, 32'h005);
        chk({16'h0, cmd_q.code, cmd_q.feature}, 32'h205A);
        finish(2, 5'b00010);
        chk({24'h0, devTf_q.status}, 32'h01);
        chk({24'h0, devTf_q.errorCause}, 32'h04);
        chk({24'h0, devTf_q.count}, 32'h03);
        chk({16'h0, devTf_q.cylHigh, devTf_q.cylLow}, 32'h1234);
        chk({16'h0, devTf_q.sectorNum, devTf_q.devHead}, 32'h07A9);
    endtask

    // One command ending with a single error event; older flags must be gone
    task automatic err_case(input ata_tf_pkg::err_evt_t e,
                            input logic [7:0]           cause);
        host.send(8'h01, 8'h00, 8'h00, 8'h00, 1'b1, 4'h0);
        finish(0, e);
        chk({24'h0, devTf_q.errorCause}, {24'h0, cause});
        chk({24'h0, devTf_q.status}, 32'h1);
    endtask

    task automatic t_errs();
        err_case(5'b10000, 8'h80);
        err_case(5'b01000, 8'h40);
        err_case(5'b00100, 8'h10);
        err_case(5'b00010, 8'h04);
        err_case(5'b00001, 8'h01);
    endtask

    task automatic t_data();
        host.send(8'h01, 8'h00, 8'h00, 8'h00, 1'b1, 4'h0);
        @(posedge clk);
        coreBufWe <= 1'b1;
        coreBufAddr <= 8'h02;
        coreBufWrData <= 16'hBEEF;
        @(posedge clk);
        coreBufWe <= 1'b0;
        host.wrWord(16'hA55A);
        host.wrWord(16'h1234);
        host.rdWord();
        #1;
        chk({hostRdValid_q, hostRdData_q}, 32'h1BEEF);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk);
            coreBufAddr <= 8'(i);
            @(posedge clk);
            #1;
            chk({16'h0, coreBufRdData_q}, i ? 32'h1234 : 32'hA55A);
        end
        finish(1, '0);
    endtask

    task automatic wrap_up();
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #100000;
        fail_count++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        t_lba();
        t_chs();
        t_errs();
        t_data();
        wrap_up();
    end
endmodule
`default_nettype wire
